// *** rtl/drv_ctrl_pkg.sv ***
// Shared constants, register map and types of the output enable and fault control block.
package drv_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TRIG_DELAY_NS = 50;
  localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

  localparam int NUM_FAULTS = 5;
  localparam int NUM_SLOTS = 5;
  localparam int NUM_BUTTONS = 4;

  // Settings in their native steps: 10 mA, 100 mV, 50 mA.
  localparam logic [8:0] BIAS_MAX = 9'h1f4;
  localparam logic [9:0] FWD_MAX = 10'h3e8;
  localparam logic [7:0] VLIM_MAX = 8'hc8;
  localparam logic [7:0] MARGIN_MAX = 8'hc8;

  localparam logic [7:0] ADDR_BIAS = 8'h00;
  localparam logic [7:0] ADDR_FWD = 8'h04;
  localparam logic [7:0] ADDR_VLIM = 8'h08;
  localparam logic [7:0] ADDR_MARGIN = 8'h0c;
  localparam logic [7:0] ADDR_TRIG = 8'h10;
  localparam logic [7:0] ADDR_FREQ = 8'h14;
  localparam logic [7:0] ADDR_WIDTH = 8'h18;
  localparam logic [7:0] ADDR_NAME = 8'h1c;
  localparam logic [7:0] ADDR_SLOT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;

  localparam int TRIG_POL_BIT = 4;
  localparam int SLOT_SAVE_BIT = 8;
  localparam int SLOT_LOAD_BIT = 9;

  localparam int FLT_INTERLOCK = 0;
  localparam int FLT_OVERVOLT = 1;
  localparam int FLT_BIAS_OC = 2;
  localparam int FLT_FWD_OC = 3;
  localparam int FLT_OVERTEMP = 4;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_TOGGLE = 1;
  localparam int IRQ_SLOT = 2;
  localparam int IRQ_BITS = 3;

  localparam int BTN_RIGHT = 0;
  localparam int BTN_LEFT = 1;
  localparam int BTN_SELECT = 2;
  localparam int BTN_TOGGLE = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TRIG_INT, TRIG_EXT, TRIG_TRK, TRIG_SINGLE} trig_src_e;
  typedef enum logic [1:0] {SEL_FWD, SEL_BIAS, SEL_BOTH} out_sel_e;
  typedef enum logic [2:0] {MENU_NO_FAULT, MENU_SHOW_ASK, MENU_VIEW, MENU_CLEAR_ASK, MENU_UPDATE} menu_e;

  typedef struct packed {
    logic [31:0] name;
    logic [1:0] trig;
    logic [31:0] freq;
    logic [31:0] width;
    logic [8:0] bias;
    logic [9:0] fwd;
    logic [7:0] vlim;
    logic [7:0] margin;
    logic polarity;
  } setup_s;

endpackage

// *** rtl/press_if.sv ***
// Carrier for one debounced button press event.
`timescale 1ns/10ps
interface press_if;
  logic press;
  modport source (output press);
  modport sink (input press);
endinterface

// *** rtl/btn_debounce.sv ***
// Debouncer that turns one raw button level into a single press pulse.
`timescale 1ns/10ps
module btn_debounce #(
  parameter int STABLE_CYC = 100000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic raw,
  press_if.source evt
);
  logic [31:0] cnt_ff;
  logic stable_ff;
  logic press_ff;

  // A level must hold unchanged for the whole window before it is believed.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 32'h0;
      stable_ff <= 1'b0;
    end else if (raw == stable_ff) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff >= 32'(STABLE_CYC - 1)) begin
      cnt_ff <= 32'h0;
      stable_ff <= raw;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      press_ff <= 1'b0;
    end else begin
      press_ff <= !stable_ff && raw != stable_ff && cnt_ff >= 32'(STABLE_CYC - 1);
    end
  end

  assign evt.press = press_ff;
endmodule

// *** rtl/drv_ctrl.sv ***
// Output enable selection, fault latching and setup storage of the current driver.
`timescale 1ns/10ps
module drv_ctrl
  import drv_ctrl_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enc_right,
  input wire logic enc_left,
  input wire logic select_btn,
  input wire logic toggle_btn,
  input wire logic ext_trig,
  input wire logic interlock_open,
  input wire logic bias_overcurrent,
  input wire logic fwd_overcurrent,
  input wire logic overtemp,
  input wire logic [7:0] vout_level,
  output logic bias_en,
  output logic fwd_en,
  output logic [8:0] bias_drive,
  output logic [10:0] pulse_amp,
  output logic polarity,
  output logic trig_start,
  output logic faulted_status,
  output logic no_fault_msg,
  output logic show_fault_prompt,
  output logic [2:0] view_fault,
  output logic hw_fault_reset,
  output logic irq
);

  press_if pif[NUM_BUTTONS] ();
  logic [NUM_BUTTONS-1:0] raw_btn;
  assign raw_btn = {toggle_btn, select_btn, enc_left, enc_right};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUTTONS; gi++) begin : g_btn
      btn_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_deb (
        .clock(clock),
        .resetn(resetn),
        .raw(raw_btn[gi]),
        .evt(pif[gi])
      );
    end
  endgenerate

  logic right_p;
  logic left_p;
  logic select_p;
  logic toggle_p;
  assign right_p = pif[BTN_RIGHT].press;
  assign left_p = pif[BTN_LEFT].press;
  assign select_p = pif[BTN_SELECT].press;
  assign toggle_p = pif[BTN_TOGGLE].press;

  // Settings and configuration held in registers.
  logic [8:0] bias_ff;
  logic [9:0] fwd_ff;
  logic [7:0] vlim_ff;
  logic [7:0] margin_ff;
  logic [1:0] trig_ff;
  logic pol_ff;
  logic [31:0] freq_ff;
  logic [31:0] width_ff;
  logic [31:0] name_ff;
  logic [2:0] slot_idx_ff;
  logic [IRQ_BITS-1:0] irq_stat_ff;
  logic [IRQ_BITS-1:0] irq_mask_ff;

  out_sel_e sel_ff;
  out_sel_e pend_sel_ff;
  menu_e menu_ff;
  logic answer_ff;
  logic [2:0] view_ff;
  logic bias_en_ff;
  logic fwd_en_ff;
  logic [NUM_FAULTS-1:0] fault_ff;
  logic clear_ff;

  // Write channel capture; address and data may arrive in either order.
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic wr_mapped;
  logic [31:0] wval;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_comb begin
    unique case (waddr_ff)
      ADDR_BIAS, ADDR_FWD, ADDR_VLIM, ADDR_MARGIN, ADDR_TRIG, ADDR_FREQ, ADDR_WIDTH, ADDR_NAME, ADDR_SLOT,
      ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  function automatic logic [31:0] status_word();
    logic [31:0] s;
    s = 32'h0;
    s[1:0] = sel_ff;
    s[3:2] = pend_sel_ff;
    s[4] = bias_en_ff;
    s[5] = fwd_en_ff;
    s[10:6] = fault_ff;
    s[11] = faulted_status;
    s[14:12] = menu_ff;
    s[17:15] = view_ff;
    s[18] = answer_ff;
    return s;
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_BIAS: rdata_ff <= {23'h0, bias_ff};
        ADDR_FWD: rdata_ff <= {22'h0, fwd_ff};
        ADDR_VLIM: rdata_ff <= {24'h0, vlim_ff};
        ADDR_MARGIN: rdata_ff <= {24'h0, margin_ff};
        ADDR_TRIG: rdata_ff <= {27'h0, pol_ff, 2'h0, trig_ff};
        ADDR_FREQ: rdata_ff <= freq_ff;
        ADDR_WIDTH: rdata_ff <= width_ff;
        ADDR_NAME: rdata_ff <= name_ff;
        ADDR_SLOT: rdata_ff <= {29'h0, slot_idx_ff};
        ADDR_STATUS: rdata_ff <= status_word();
        ADDR_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
        ADDR_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        default: begin
          rdata_ff <= 32'h0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Setup storage has no reset so that it keeps its contents; the carrier must be battery-backed.
  setup_s slots_ff [NUM_SLOTS];
  setup_s cur_setup;
  logic slot_ok;
  logic save_req;
  logic load_req;

  assign wval = merge(32'h0, wdata_ff, wstrb_ff);
  assign slot_ok = wval[2:0] < 3'(NUM_SLOTS);
  assign save_req = do_write && waddr_ff == ADDR_SLOT && wval[SLOT_SAVE_BIT] && slot_ok;
  assign load_req = do_write && waddr_ff == ADDR_SLOT && wval[SLOT_LOAD_BIT] && slot_ok && !save_req;
  assign cur_setup = '{name: name_ff, trig: trig_ff, freq: freq_ff, width: width_ff, bias: bias_ff,
                       fwd: fwd_ff, vlim: vlim_ff, margin: margin_ff, polarity: pol_ff};

  always_ff @(posedge clock) begin
    if (save_req) begin
      slots_ff[wval[2:0]] <= cur_setup;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slot_idx_ff <= 3'h0;
    end else if (save_req || load_req) begin
      slot_idx_ff <= wval[2:0];
    end
  end

  logic [31:0] wm;
  assign wm = merge(32'h0, wdata_ff, wstrb_ff);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bias_ff <= 9'h0;
      fwd_ff <= 10'h0;
      vlim_ff <= VLIM_MAX;
      margin_ff <= 8'h0;
      trig_ff <= TRIG_INT;
      pol_ff <= 1'b0;
      freq_ff <= 32'h0;
      width_ff <= 32'h0;
      name_ff <= 32'h0;
    end else if (load_req) begin
      name_ff <= slots_ff[wval[2:0]].name;
      trig_ff <= slots_ff[wval[2:0]].trig;
      freq_ff <= slots_ff[wval[2:0]].freq;
      width_ff <= slots_ff[wval[2:0]].width;
      bias_ff <= slots_ff[wval[2:0]].bias;
      fwd_ff <= slots_ff[wval[2:0]].fwd;
      vlim_ff <= slots_ff[wval[2:0]].vlim;
      margin_ff <= slots_ff[wval[2:0]].margin;
      pol_ff <= slots_ff[wval[2:0]].polarity;
    end else if (do_write) begin
      unique case (waddr_ff)
        ADDR_BIAS: bias_ff <= wm[8:0] > BIAS_MAX || wm[31:9] != 23'h0 ? BIAS_MAX : wm[8:0];
        ADDR_FWD: fwd_ff <= wm[9:0] > FWD_MAX || wm[31:10] != 22'h0 ? FWD_MAX : wm[9:0];
        ADDR_VLIM: vlim_ff <= wm[7:0] > VLIM_MAX || wm[31:8] != 24'h0 ? VLIM_MAX : wm[7:0];
        ADDR_MARGIN: margin_ff <= wm[7:0] > MARGIN_MAX || wm[31:8] != 24'h0 ? MARGIN_MAX : wm[7:0];
        ADDR_TRIG: begin
          trig_ff <= wm[1:0];
          pol_ff <= wm[TRIG_POL_BIT];
        end
        ADDR_FREQ: freq_ff <= merge(freq_ff, wdata_ff, wstrb_ff);
        ADDR_WIDTH: width_ff <= merge(width_ff, wdata_ff, wstrb_ff);
        ADDR_NAME: name_ff <= merge(name_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  // Fault flags: a live cause always wins over a clear in the same cycle.
  logic [NUM_FAULTS-1:0] cause;
  assign cause[FLT_INTERLOCK] = interlock_open;
  assign cause[FLT_OVERVOLT] = vout_level > vlim_ff;
  assign cause[FLT_BIAS_OC] = bias_overcurrent;
  assign cause[FLT_FWD_OC] = fwd_overcurrent;
  assign cause[FLT_OVERTEMP] = overtemp;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_ff <= '0;
    end else begin
      fault_ff <= cause | (fault_ff & ~{NUM_FAULTS{clear_ff}});
    end
  end

  assign faulted_status = |fault_ff;

  function automatic logic [2:0] next_fault(input logic [NUM_FAULTS-1:0] f, input logic [2:0] from);
    logic [2:0] r;
    logic found;
    r = 3'(NUM_FAULTS);
    found = 1'b0;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (!found && f[i] && 3'(i) >= from) begin
        r = 3'(i);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // Operator menu for fault handling and output selection.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      menu_ff <= MENU_NO_FAULT;
      answer_ff <= 1'b1;
      view_ff <= 3'h0;
      clear_ff <= 1'b0;
    end else begin
      clear_ff <= 1'b0;
      if (right_p) begin
        answer_ff <= 1'b1;
      end else if (left_p) begin
        answer_ff <= 1'b0;
      end
      unique case (menu_ff)
        MENU_NO_FAULT: begin
          if (faulted_status) begin
            menu_ff <= MENU_SHOW_ASK;
            answer_ff <= 1'b1;
          end
        end
        MENU_SHOW_ASK: begin
          if (select_p && answer_ff) begin
            menu_ff <= MENU_VIEW;
            view_ff <= next_fault(fault_ff, 3'h0);
          end else if (select_p) begin
            menu_ff <= MENU_CLEAR_ASK;
            answer_ff <= 1'b1;
          end
        end
        MENU_VIEW: begin
          if (select_p) begin
            if (next_fault(fault_ff, view_ff + 3'h1) >= 3'(NUM_FAULTS)) begin
              menu_ff <= MENU_CLEAR_ASK;
              answer_ff <= 1'b1;
            end else begin
              view_ff <= next_fault(fault_ff, view_ff + 3'h1);
            end
          end
        end
        MENU_CLEAR_ASK: begin
          if (select_p && answer_ff) begin
            clear_ff <= 1'b1;
            menu_ff <= MENU_NO_FAULT;
          end else if (select_p) begin
            menu_ff <= MENU_UPDATE;
          end
        end
        MENU_UPDATE: begin
          if (select_p) begin
            menu_ff <= MENU_NO_FAULT;
          end
        end
      endcase
    end
  end

  assign no_fault_msg = !faulted_status;
  assign show_fault_prompt = faulted_status;
  assign view_fault = view_ff;
  assign hw_fault_reset = clear_ff;

  // Output selection is edited on a pending copy so the toggle keeps its old targets until select.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_sel_ff <= SEL_BOTH;
      sel_ff <= SEL_BOTH;
    end else if (menu_ff == MENU_NO_FAULT) begin
      if (right_p) begin
        pend_sel_ff <= pend_sel_ff == SEL_FWD ? SEL_BIAS : SEL_BOTH;
      end else if (left_p) begin
        pend_sel_ff <= pend_sel_ff == SEL_BOTH ? SEL_BIAS : SEL_FWD;
      end
      if (select_p) begin
        sel_ff <= pend_sel_ff;
      end
    end
  end

  logic tog_bias;
  logic tog_fwd;
  assign tog_bias = toggle_p && sel_ff != SEL_FWD;
  assign tog_fwd = toggle_p && sel_ff != SEL_BIAS;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bias_en_ff <= 1'b0;
      fwd_en_ff <= 1'b0;
    end else if (faulted_status) begin
      bias_en_ff <= 1'b0;
      fwd_en_ff <= 1'b0;
    end else begin
      bias_en_ff <= bias_en_ff ^ tog_bias;
      fwd_en_ff <= fwd_en_ff ^ tog_fwd;
    end
  end

  assign bias_en = bias_en_ff && !faulted_status;
  assign fwd_en = fwd_en_ff && !faulted_status;
  assign polarity = pol_ff;

  logic [8:0] bias_drive_ff;
  logic [10:0] pulse_amp_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bias_drive_ff <= 9'h0;
      pulse_amp_ff <= 11'h0;
    end else begin
      bias_drive_ff <= bias_en ? bias_ff : 9'h0;
      pulse_amp_ff <= 11'((bias_en ? {2'h0, bias_ff} : 11'h0) + (fwd_en ? {1'b0, fwd_ff} : 11'h0));
    end
  end

  assign bias_drive = bias_drive_ff;
  assign pulse_amp = pulse_amp_ff;

  // External trigger edge passes through a fixed delay line before starting the outputs.
  logic trig_prev_ff;
  logic [TRIG_DELAY_CYC-1:0] trig_dly_ff;
  logic ext_mode;
  assign ext_mode = trig_ff == TRIG_EXT || trig_ff == TRIG_TRK;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trig_prev_ff <= 1'b0;
      trig_dly_ff <= '0;
    end else begin
      trig_prev_ff <= ext_trig;
      trig_dly_ff <= TRIG_DELAY_CYC'({trig_dly_ff, ext_mode && ext_trig && !trig_prev_ff});
    end
  end

  assign trig_start = trig_dly_ff[TRIG_DELAY_CYC-1] && !faulted_status;

  // Interrupt status: hardware set wins over a write-one clear in the same cycle.
  logic [IRQ_BITS-1:0] irq_evt;
  logic [IRQ_BITS-1:0] irq_clr;
  assign irq_evt[IRQ_FAULT] = |(cause & ~fault_ff);
  assign irq_evt[IRQ_TOGGLE] = toggle_p;
  assign irq_evt[IRQ_SLOT] = save_req || load_req;
  assign irq_clr = do_write && waddr_ff == ADDR_IRQ_STAT ? wm[IRQ_BITS-1:0] : '0;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= irq_evt | (irq_stat_ff & ~irq_clr);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_mask_ff <= '0;
    end else if (do_write && waddr_ff == ADDR_IRQ_MASK) begin
      irq_mask_ff <= wm[IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

// *** tb/drv_ctrl_assertions.sv ***
// Concurrent checks on the ports of the driver control block.
`timescale 1ns/10ps
module drv_ctrl_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic toggle_btn,
  input wire logic ext_trig,
  input wire logic interlock_open,
  input wire logic bias_en,
  input wire logic fwd_en,
  input wire logic [8:0] bias_drive,
  input wire logic [10:0] pulse_amp,
  input wire logic trig_start,
  input wire logic faulted_status,
  input wire logic no_fault_msg,
  input wire logic show_fault_prompt,
  input wire logic hw_fault_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_fault_forces_off: assert property (faulted_status |-> !bias_en && !fwd_en)
    else $error("source enabled while faulted");
  chk_status_msgs: assert property (no_fault_msg == !faulted_status && show_fault_prompt == faulted_status)
    else $error("status messages disagree with fault state");
  chk_cause_latches: assert property (interlock_open |-> ##[1:3] faulted_status)
    else $error("interlock did not raise a fault");
  chk_sticky_flags: assert property ($fell(faulted_status) |-> hw_fault_reset || $past(hw_fault_reset))
    else $error("fault dropped without a clear");
  chk_trig_single: assert property (trig_start |=> !trig_start)
    else $error("trigger start longer than one cycle");
  chk_trig_cause: assert property (trig_start |-> $past(ext_trig, 1) || $past(ext_trig, 2) || $past(ext_trig, 3))
    else $error("trigger start without external trigger");
  chk_drive_gated: assert property (bias_drive != 9'h000 |-> $past(bias_en))
    else $error("bias drive without bias enable");
  chk_sum_amp: assert property (!$past(fwd_en) |-> pulse_amp == {2'h0, bias_drive})
    else $error("pulse amplitude differs from bias alone");
  chk_drive_range: assert property (bias_drive <= 9'h1f4 && pulse_amp <= 11'h5dc)
    else $error("drive code above its range");
  chk_toggle_cause: assert property ($rose(bias_en) || $rose(fwd_en) |-> $past(toggle_btn, 4))
    else $error("enable rose without a held toggle");
  cover property (hw_fault_reset);
  cover property (trig_start);
  cover property (bias_en && fwd_en);
endmodule

bind drv_ctrl drv_ctrl_assertions drv_ctrl_assertions_inst (.clock, .resetn, .toggle_btn, .ext_trig,
  .interlock_open, .bias_en, .fwd_en, .bias_drive, .pulse_amp, .trig_start, .faulted_status,
  .no_fault_msg, .show_fault_prompt, .hw_fault_reset);

// *** tb/panel_model.sv ***
// Front panel operator and diode load facing the driver control block.
`timescale 1ns/10ps
module panel_model (
  input wire logic clock,
  output logic [3:0] buttons,
  output logic [3:0] causes,
  output logic [7:0] vout_level
);
  initial begin
    buttons = 4'h0;
    causes = 4'h0;
    vout_level = 8'h00;
  end
  // Held well past the debounce window both ways, so each touch is one clean press.
  task automatic press(input int b);
    @(posedge clock);
    buttons[b] <= 1'b1;
    repeat (10) @(posedge clock);
    buttons[b] <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  task automatic load(input logic [3:0] c, input logic [7:0] v);
    @(posedge clock);
    causes <= c;
    vout_level <= v;
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** tb/output_enable_fault_control_bench.sv ***
// Self-checking bench of the output enable and fault control block.
`timescale 1ns/10ps
module output_enable_fault_control_bench;
  import drv_ctrl_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, ext_trig = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, vout_level;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bias_en, fwd_en;
  logic polarity, trig_start, faulted_status, no_fault_msg, show_fault_prompt, hw_fault_reset, irq;
  logic [8:0] bias_drive;
  logic [10:0] pulse_amp;
  logic [2:0] view_fault;
  logic [3:0] buttons, causes;
  int num_errors = 0, check_count = 0, resets_seen = 0, trigs_seen = 0;

  always #25 clock = ~clock;
  always @(negedge clock) begin
    if (hw_fault_reset === 1'b1) resets_seen++;
    if (trig_start === 1'b1) trigs_seen++;
  end

  drv_ctrl #(.DEBOUNCE_CYCLES(4)) drv_ctrl_inst (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_right(buttons[BTN_RIGHT]),
    .enc_left(buttons[BTN_LEFT]), .select_btn(buttons[BTN_SELECT]), .toggle_btn(buttons[BTN_TOGGLE]),
    .ext_trig, .interlock_open(causes[0]), .bias_overcurrent(causes[1]), .fwd_overcurrent(causes[2]),
    .overtemp(causes[3]), .vout_level, .bias_en, .fwd_en, .bias_drive, .pulse_amp, .polarity,
    .trig_start, .faulted_status, .no_fault_msg, .show_fault_prompt, .view_fault, .hw_fault_reset, .irq);
  panel_model panel_model_inst (.clock, .buttons, .causes, .vout_level);

  task automatic finish_test;
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Compares away from the edge, so register updates of the last edge have landed.
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    @(negedge clock);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Handshakes are judged on values settled at the falling edge before the taking edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    while (!done) begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 40) begin
        num_errors++;
        finish_test();
      end
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", q & m, e);
  endtask
  task automatic p(input int b);
    panel_model_inst.press(b);
  endtask

  task automatic s_regs;
    rd(ADDR_VLIM, 32'hc8);
    bus(1'b1, ADDR_BIAS, 32'h258);
    rd(ADDR_BIAS, 32'h1f4);
    bus(1'b1, ADDR_FWD, 32'h7d0);
    rd(ADDR_FWD, 32'h3e8);
    bus(1'b0, 8'h40, 32'h0);
    chk("rresp", r, RESP_SLVERR);
    bus(1'b1, 8'h40, 32'h0);
    chk("bresp", r, RESP_SLVERR);
    st(32'hf, 32'ha);
  endtask
  task automatic s_select;
    bus(1'b1, ADDR_BIAS, 32'h12c);
    bus(1'b1, ADDR_FWD, 32'h1c2);
    p(BTN_LEFT);
    st(32'hf, 32'h6);
    p(BTN_SELECT);
    p(BTN_TOGGLE);
    chk("enables", {bias_en, fwd_en, pulse_amp}, 13'h112c);
    p(BTN_LEFT);
    p(BTN_SELECT);
    p(BTN_TOGGLE);
    chk("enables", {bias_en, fwd_en, pulse_amp, bias_drive}, 22'h35dd2c);
    p(BTN_RIGHT);
    p(BTN_RIGHT);
    st(32'hf, 32'h8);
    p(BTN_SELECT);
    p(BTN_TOGGLE);
    chk("enables", {bias_en, fwd_en, irq}, 3'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h7);
    chk("irq", irq, 1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h7);
    chk("irq", irq, 1'b0);
  endtask
  task automatic s_trig;
    for (int m = 2; m >= 0; m--) begin
      bus(1'b1, ADDR_TRIG, 32'h10 | m);
      ext_trig <= 1'b1;
      repeat (4) @(posedge clock);
      ext_trig <= 1'b0;
      repeat (4) @(posedge clock);
      chk("trig_start", trigs_seen, 32'(m == 0 ? 2 : 3 - m));
    end
    chk("polarity", polarity, 1'b1);
  endtask
  task automatic s_slots;
    logic [31:0] v [8] = '{32'h7b, 32'h2d0, 32'h64, 32'h32, 32'h12, 32'h1234, 32'h56, 32'h61626364};
    for (int i = 0; i < 8; i++) bus(1'b1, 8'(i * 4), v[i]);
    bus(1'b1, ADDR_SLOT, 32'h104);
    for (int i = 0; i < 8; i++) bus(1'b1, 8'(i * 4), 32'h0);
    bus(1'b1, ADDR_SLOT, 32'h204);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), v[i]);
  endtask
  task automatic s_fault;
    p(BTN_TOGGLE);
    panel_model_inst.load(4'h1, 8'h00);
    chk("flags", {faulted_status, show_fault_prompt, no_fault_msg, bias_en, fwd_en}, 5'h18);
    panel_model_inst.load(4'h0, 8'h00);
    p(BTN_TOGGLE);
    chk("flags", {faulted_status, bias_en, fwd_en}, 3'h4);
    p(BTN_SELECT);
    chk("view_fault", view_fault, 3'h0);
    p(BTN_SELECT);
    p(BTN_SELECT);
    chk("cleared", {resets_seen[3:0], faulted_status}, 5'h2);
    bus(1'b1, ADDR_VLIM, 32'h32);
    panel_model_inst.load(4'h8, 8'h3c);
    panel_model_inst.load(4'h8, 8'h00);
    st(32'h7c0, 32'h480);
    p(BTN_SELECT);
    chk("view_fault", view_fault, 3'h1);
    p(BTN_SELECT);
    chk("view_fault", view_fault, 3'h4);
    p(BTN_SELECT);
    p(BTN_SELECT);
    st(32'hfc0, 32'hc00);
    p(BTN_LEFT);
    p(BTN_SELECT);
    p(BTN_LEFT);
    p(BTN_SELECT);
    st(32'h7000, 32'h4000);
    chk("resets", resets_seen, 32'h2);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    s_regs();
    s_select();
    s_trig();
    s_slots();
    s_fault();
    finish_test();
  end
endmodule
